// >>> design/tcc_pkg.sv
// Shared constants, types and field layouts of the three-channel interval counter
package tcc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int NUM_CH = 3;
  localparam int CNT_W  = 16;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 4;

  // Byte locations of the ports
  localparam logic [ADDR_W-1:0] OFS_CH0  = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CH1  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_CH2  = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'hc;

  // Control byte fields
  localparam int SEL_HI  = 7;
  localparam int SEL_LO  = 6;
  localparam int FMT_HI  = 5;
  localparam int FMT_LO  = 4;
  localparam int MODE_B2 = 3;
  localparam int MODE_B1 = 2;
  localparam int MODE_B0 = 1;
  localparam int BCD_BIT = 0;

  localparam logic [1:0] SEL_ILLEGAL = 2'h3;
  localparam logic [1:0] FMT_LATCH   = 2'h0;
  localparam logic [1:0] FMT_LOW     = 2'h1;
  localparam logic [1:0] FMT_HIGH    = 2'h2;
  localparam logic [1:0] FMT_BOTH    = 2'h3;

  // Reset values and count constants
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 16'h0001;
  localparam logic [CNT_W-1:0]  CNT_TWO   = 16'h0002;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0]        STEP_ONE   = 2'h1;
  localparam logic [1:0]        STEP_TWO   = 2'h2;
  localparam logic [1:0]        STEP_THREE = 2'h3;
  localparam logic [3:0]        BCD_TEN    = 4'ha;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [5:0] {
    MODE_TC_IRQ  = 6'h01,
    MODE_ONESHOT = 6'h02,
    MODE_RATE    = 6'h04,
    MODE_SQUARE  = 6'h08,
    MODE_SW_STB  = 6'h10,
    MODE_HW_STB  = 6'h20
  } tcc_mode_e;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] wdata;
  } tcc_bus_req_s;

  typedef struct packed {
    tcc_mode_e        mode;
    logic [1:0]       fmt;
    logic             bcd;
    logic [CNT_W-1:0] init;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] held;
    logic             held_ok;
    logic             wr_hi;
    logic             rd_hi;
    logic             pend;
    logic             have;
    logic             run;
    logic             trig;
    logic             first;
    logic             out;
  } tcc_chan_s;

endpackage

// >>> design/tcc_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module tcc_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  ////////////////////////////////////////////////////////////////////////////
  // Only the second stage is visible outside
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // tcc_sync

// >>> design/tcc_step.sv
// Binary or four-decade decimal down-step by one, two or three
`timescale 1ns/1ps
module tcc_step
  import tcc_pkg::*;
(
  input  wire logic [CNT_W-1:0] value,
  input  wire logic [1:0]       amount,
  input  wire logic             bcd,
  output logic      [CNT_W-1:0] result
);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [4:0] diff;
    logic [3:0] borrow;
    diff   = 5'h00;
    borrow = {2'h0, amount};
    result = CNT_ZERO;
    if (bcd) begin
      // Decades borrow from one another; zero wraps to 9999
      for (int d = 0; d < 4; d++) begin
        diff = {1'b0, value[d*4 +: 4]} - {1'b0, borrow};
        if (diff[4]) begin
          result[d*4 +: 4] = diff[3:0] + BCD_TEN;
          borrow           = 4'h1;
        end else begin
          result[d*4 +: 4] = diff[3:0];
          borrow           = 4'h0;
        end
      end
    end else begin
      result = value - {14'h0000, amount};
    end
  end

endmodule // tcc_step

// >>> design/tcc_top.sv
// Three-channel programmable 16-bit interval counter with byte-wide port access
`timescale 1ns/1ps
// Function
// - Three independent 16-bit channels, each programmable to one of six modes.
// - Control bits 7:6 pick channel 0, 1 or 2; pattern 11 is ignored.
// - Bits 5:4 choose latch, low byte, high byte, or low then high.
// - Bits 3:1 choose mode; bit 3 ignored for modes two and three.
// - Bit 0 selects binary sixteen-bit or four-decade decimal counting.
// - Mode 0 output low from setup, high at terminal count, counting continues.
// - Mode 0 rewrite: first byte halts counting, second byte restarts it.
// - Mode 1 output low after gate rise, high at terminal count, retriggerable.
// - Mode 1 new count waits for the next trigger.
// - Mode 1 count reads never disturb the pulse.
// - Mode 2 divides by N, one low clock each period, reload next period.
// - Mode 2 low gate forces output high; gate rise restarts count.
// - Mode 2 output stays high after setup until a count is loaded.
// - Mode 3 steps by two, toggles and reloads at terminal count.
// - Mode 3 odd count: high (N+1)/2, low (N-1)/2 via adjusted first step.
// - Mode 4 output high, counts after load, one-clock low pulse at terminal count.
// - Mode 4 reload applies next clock; low gate suspends counting.
// - Mode 5 counts after trigger rise, one-clock low pulse, retriggerable.
module tcc_top
  import tcc_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire tcc_bus_req_s      bus_req,
  output logic      [BYTE_W-1:0] bus_rdata,
  input  wire logic [NUM_CH-1:0] cnt_clk_pin,
  input  wire logic [NUM_CH-1:0] cnt_gate_pin,
  output logic      [NUM_CH-1:0] cnt_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Mode field decode; M2 is a don't-care when M1 is set
  function automatic tcc_mode_e decode_mode(input logic [BYTE_W-1:0] b);
    tcc_mode_e m;
    m = MODE_TC_IRQ;
    if (b[MODE_B1]) begin
      m = b[MODE_B0] ? MODE_SQUARE : MODE_RATE;
    end else if (b[MODE_B2]) begin
      m = b[MODE_B0] ? MODE_HW_STB : MODE_SW_STB;
    end else begin
      m = b[MODE_B0] ? MODE_ONESHOT : MODE_TC_IRQ;
    end
    return m;
  endfunction

  // Port address to channel index, NUM_CH when not a count port
  function automatic logic [1:0] port_index(input logic [ADDR_W-1:0] a);
    logic [1:0] idx;
    case (a)
      OFS_CH0: idx = 2'h0;
      OFS_CH1: idx = 2'h1;
      OFS_CH2: idx = 2'h2;
      default: idx = 2'h3;
    endcase
    return idx;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  tcc_chan_s        chn      [NUM_CH];
  tcc_chan_s        next_chn [NUM_CH];
  logic [BYTE_W-1:0] next_rdata;
  logic [NUM_CH-1:0] clk_s;
  logic [NUM_CH-1:0] gate_s;
  logic [NUM_CH-1:0] clk_d;
  logic [NUM_CH-1:0] gate_d;
  logic [NUM_CH-1:0] tick;
  logic [NUM_CH-1:0] rise;
  logic [1:0]        step_amt [NUM_CH];
  logic [CNT_W-1:0]  step_res [NUM_CH];

  ////////////////////////////////////////////////////////////////////////////
  // Pins come from another domain
  tcc_sync #(
    .WIDTH (2*NUM_CH)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d        ({cnt_gate_pin, cnt_clk_pin}),
    .q        ({gate_s, clk_s})
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clk_d  <= '0;
      gate_d <= '0;
    end else begin
      clk_d  <= clk_s;
      gate_d <= gate_s;
    end
  end

  // Counting happens on the falling edge of each channel clock
  assign tick = clk_d & ~clk_s;
  assign rise = gate_s & ~gate_d;

  ////////////////////////////////////////////////////////////////////////////
  // One step unit per channel
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    always_comb begin
      step_amt[g] = STEP_ONE;
      if (chn[g].mode == MODE_SQUARE) begin
        step_amt[g] = STEP_TWO;
        // Odd count: first high step is one, first low step is three
        if (chn[g].first && chn[g].init[0]) begin
          step_amt[g] = chn[g].out ? STEP_ONE : STEP_THREE;
        end
      end
    end

    tcc_step u_step (
      .value  (chn[g].cnt),
      .amount (step_amt[g]),
      .bcd    (chn[g].bcd),
      .result (step_res[g])
    );

    assign cnt_out[g] = chn[g].out;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [1:0]        pidx;
    logic [1:0]        csel;
    logic [CNT_W-1:0]  rval;
    logic              last;
    pidx       = port_index(bus_req.addr);
    csel       = bus_req.wdata[SEL_HI:SEL_LO];
    rval       = CNT_ZERO;
    last       = 1'b0;
    next_rdata = bus_rdata;
    for (int i = 0; i < NUM_CH; i++) begin
      next_chn[i] = chn[i];
      // Stale triggers are dropped by every tick
      if (tick[i]) begin
        next_chn[i].trig = 1'b0;
      end
      case (chn[i].mode)
        MODE_TC_IRQ: begin
          if (tick[i]) begin
            if (chn[i].pend) begin
              next_chn[i].cnt  = chn[i].init;
              next_chn[i].pend = 1'b0;
              next_chn[i].run  = 1'b1;
            end else if (chn[i].run && gate_s[i]) begin
              // Keeps decrementing past terminal count
              next_chn[i].cnt = step_res[i];
              if (chn[i].cnt == CNT_ONE) begin
                next_chn[i].out = 1'b1;
              end
            end
          end
        end
        MODE_ONESHOT: begin
          if (tick[i]) begin
            if (chn[i].trig && chn[i].have) begin
              // Fresh count taken only here, on a trigger, which may come mid-pulse
              next_chn[i].cnt  = chn[i].init;
              next_chn[i].out  = 1'b0;
              next_chn[i].run  = 1'b1;
              next_chn[i].pend = 1'b0;
            end else if (chn[i].run) begin
              next_chn[i].cnt = step_res[i];
              if (chn[i].cnt == CNT_ONE) begin
                next_chn[i].out = 1'b1;
                next_chn[i].run = 1'b0;
              end
            end
          end
        end
        MODE_RATE: begin
          if (!gate_s[i]) begin
            next_chn[i].out = 1'b1;
          end
          if (tick[i]) begin
            if ((chn[i].pend && !chn[i].run) || (chn[i].trig && chn[i].have)) begin
              next_chn[i].cnt  = chn[i].init;
              next_chn[i].pend = 1'b0;
              next_chn[i].run  = 1'b1;
              next_chn[i].out  = 1'b1;
            end else if (chn[i].run && gate_s[i]) begin
              if (chn[i].cnt == CNT_TWO) begin
                next_chn[i].out = 1'b0;
                next_chn[i].cnt = step_res[i];
              end else if (chn[i].cnt == CNT_ONE) begin
                // Reload picks up any count written during the period
                next_chn[i].out  = 1'b1;
                next_chn[i].cnt  = chn[i].init;
                next_chn[i].pend = 1'b0;
              end else begin
                next_chn[i].cnt = step_res[i];
              end
            end
          end
        end
        MODE_SQUARE: begin
          if (!gate_s[i]) begin
            next_chn[i].out = 1'b1;
          end
          if (tick[i]) begin
            if ((chn[i].pend && !chn[i].run) || (chn[i].trig && chn[i].have)) begin
              next_chn[i].cnt   = chn[i].init;
              next_chn[i].first = 1'b1;
              next_chn[i].pend  = 1'b0;
              next_chn[i].run   = 1'b1;
              next_chn[i].out   = 1'b1;
            end else if (chn[i].run && gate_s[i]) begin
              next_chn[i].cnt   = step_res[i];
              next_chn[i].first = 1'b0;
              if (step_res[i] == CNT_ZERO) begin
                next_chn[i].out   = ~chn[i].out;
                next_chn[i].cnt   = chn[i].init;
                next_chn[i].first = 1'b1;
                next_chn[i].pend  = 1'b0;
              end
            end
          end
        end
        MODE_SW_STB: begin
          if (tick[i]) begin
            // Low strobe lasts exactly one channel clock
            if (!chn[i].out) begin
              next_chn[i].out = 1'b1;
            end
            if (chn[i].pend) begin
              next_chn[i].cnt  = chn[i].init;
              next_chn[i].pend = 1'b0;
              next_chn[i].run  = 1'b1;
            end else if (chn[i].run && gate_s[i]) begin
              next_chn[i].cnt = step_res[i];
              if (chn[i].cnt == CNT_ONE) begin
                next_chn[i].out = 1'b0;
                next_chn[i].run = 1'b0;
              end
            end
          end
        end
        MODE_HW_STB: begin
          if (tick[i]) begin
            if (!chn[i].out) begin
              next_chn[i].out = 1'b1;
            end
            if (chn[i].trig && chn[i].have) begin
              next_chn[i].cnt  = chn[i].init;
              next_chn[i].run  = 1'b1;
              next_chn[i].pend = 1'b0;
            end else if (chn[i].run) begin
              next_chn[i].cnt = step_res[i];
              if (chn[i].cnt == CNT_ONE) begin
                next_chn[i].out = 1'b0;
                next_chn[i].run = 1'b0;
              end
            end
          end
        end
        default: begin
          next_chn[i].mode = MODE_TC_IRQ;
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus writes win over counting in the same cycle
    if (bus_req.wr) begin
      if (bus_req.addr == OFS_CTRL && csel != SEL_ILLEGAL) begin
        if (bus_req.wdata[FMT_HI:FMT_LO] == FMT_LATCH) begin
          // A second latch before readout keeps the first snapshot
          if (!chn[csel].held_ok) begin
            next_chn[csel].held    = chn[csel].cnt;
            next_chn[csel].held_ok = 1'b1;
          end
        end else begin
          next_chn[csel].mode    = decode_mode(bus_req.wdata);
          next_chn[csel].fmt     = bus_req.wdata[FMT_HI:FMT_LO];
          next_chn[csel].bcd     = bus_req.wdata[BCD_BIT];
          next_chn[csel].out     = decode_mode(bus_req.wdata) != MODE_TC_IRQ;
          next_chn[csel].run     = 1'b0;
          next_chn[csel].pend    = 1'b0;
          next_chn[csel].have    = 1'b0;
          next_chn[csel].first   = 1'b0;
          next_chn[csel].trig    = 1'b0;
          next_chn[csel].wr_hi   = 1'b0;
          next_chn[csel].rd_hi   = 1'b0;
          next_chn[csel].held_ok = 1'b0;
        end
      end else if (pidx != SEL_ILLEGAL) begin
        last = 1'b1;
        case (chn[pidx].fmt)
          FMT_LOW: begin
            next_chn[pidx].init = {BYTE_ZERO, bus_req.wdata};
          end
          FMT_HIGH: begin
            next_chn[pidx].init = {bus_req.wdata, BYTE_ZERO};
          end
          FMT_BOTH: begin
            if (!chn[pidx].wr_hi) begin
              next_chn[pidx].init[BYTE_W-1:0] = bus_req.wdata;
              next_chn[pidx].wr_hi            = 1'b1;
              last                            = 1'b0;
              if (chn[pidx].mode == MODE_TC_IRQ) begin
                next_chn[pidx].run = 1'b0;
              end
            end else begin
              next_chn[pidx].init[CNT_W-1:BYTE_W] = bus_req.wdata;
              next_chn[pidx].wr_hi                = 1'b0;
            end
          end
          default: begin
            // Unprogrammed channel: data is dropped
            last = 1'b0;
          end
        endcase
        if (last) begin
          next_chn[pidx].pend = 1'b1;
          next_chn[pidx].have = 1'b1;
          if (chn[pidx].mode == MODE_TC_IRQ) begin
            next_chn[pidx].out = 1'b0;
            next_chn[pidx].run = 1'b0;
          end
        end
      end
    end else if (bus_req.rd && pidx != SEL_ILLEGAL) begin
      // Reads touch only the byte pointer and latch, never the count
      rval = chn[pidx].held_ok ? chn[pidx].held : chn[pidx].cnt;
      last = 1'b1;
      case (chn[pidx].fmt)
        FMT_HIGH: begin
          next_rdata = rval[CNT_W-1:BYTE_W];
        end
        FMT_BOTH: begin
          next_rdata           = chn[pidx].rd_hi ? rval[CNT_W-1:BYTE_W]
                                                 : rval[BYTE_W-1:0];
          last                 = chn[pidx].rd_hi;
          next_chn[pidx].rd_hi = ~chn[pidx].rd_hi;
        end
        default: begin
          next_rdata = rval[BYTE_W-1:0];
        end
      endcase
      if (last) begin
        next_chn[pidx].held_ok = 1'b0;
      end
    end else if (bus_req.rd) begin
      next_rdata = BYTE_ZERO;
    end

    // Gate rise recorded last so a concurrent clear never loses it
    for (int i = 0; i < NUM_CH; i++) begin
      if (rise[i]) begin
        next_chn[i].trig = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_rdata <= BYTE_ZERO;
      for (int i = 0; i < NUM_CH; i++) begin
        chn[i] <= '{mode: MODE_TC_IRQ, fmt: FMT_LATCH, init: CNT_ZERO, cnt: CNT_ZERO,
                    held: CNT_ZERO, default: 1'b0};
      end
    end else begin
      bus_rdata <= next_rdata;
      for (int i = 0; i < NUM_CH; i++) begin
        chn[i] <= next_chn[i];
      end
    end
  end

endmodule // tcc_top

// >>> test/tcc_monitor.sv
// Port checker of the interval counter
`timescale 1ns/1ps
module tcc_monitor
  import tcc_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst,
  input wire tcc_bus_req_s      bus_req,
  input wire logic [BYTE_W-1:0] bus_rdata,
  input wire logic [NUM_CH-1:0] cnt_clk_pin,
  input wire logic [NUM_CH-1:0] cnt_gate_pin,
  input wire logic [NUM_CH-1:0] cnt_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  logic [2:0] m0, next_m0;
  logic [3:0] quiet, next_quiet, glow, next_glow;
  logic [5:0] pins_q;
  logic       wrote, next_wrote, ctl0, wr0, ev, rd_t;
  assign rd_t = bus_req.rd && !bus_req.wr;
  // Latch commands leave the mode alone
  assign ctl0 = bus_req.wr && bus_req.addr == OFS_CTRL && bus_req.wdata[7:4] inside {4'h1, 4'h2, 4'h3};
  assign wr0 = ctl0 || (bus_req.wr && bus_req.addr == OFS_CH0);
  assign ev = bus_req.wr || {cnt_clk_pin, cnt_gate_pin} != pins_q;
  always_comb begin
    next_m0 = ctl0 ? bus_req.wdata[3:1] : m0;
    next_quiet = ev ? 4'h0 : quiet + {3'h0, quiet != 4'hf};
    next_glow = cnt_gate_pin[0] ? 4'h0 : glow + {3'h0, glow != 4'hf};
    next_wrote = wr0 || (wrote && cnt_out[0]);
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      m0 <= 3'h0;
      quiet <= 4'h0;
      glow <= 4'h0;
      wrote <= 1'b0;
      pins_q <= 6'h00;
    end else begin
      m0 <= next_m0;
      quiet <= next_quiet;
      glow <= next_glow;
      wrote <= next_wrote;
      pins_q <= {cnt_clk_pin, cnt_gate_pin};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence rd_idle; rd_t && (bus_req.addr[1:0] != 2'h0 || bus_req.addr == OFS_CTRL); endsequence
  sequence set_m0; ctl0 && bus_req.wdata[3:1] == 3'h0; endsequence
  sequence set_hi; ctl0 && (bus_req.wdata[2:1] == 2'h2 || bus_req.wdata[3:1] == 3'h4); endsequence
  rdata_hold_a: assert property (!rd_t |=> $stable(bus_rdata))
    else $error("read data moved without a read");
  idle_read_a: assert property (rd_idle |=> bus_rdata == BYTE_ZERO)
    else $error("control or unmapped read not zero");
  quiet_out_a: assert property (quiet > 4'h7 && !ev |=> $stable(cnt_out))
    else $error("output moved with no cause");
  gate_high_a: assert property (m0[1] && glow > 4'h5 |-> cnt_out[0])
    else $error("low gate did not force output high");
  mode0_low_a: assert property (set_m0 |-> ##[1:2] !cnt_out[0])
    else $error("output not low after mode 0 set");
  set_high_a: assert property (set_hi |-> ##[1:2] cnt_out[0])
    else $error("output not high after mode set");
  strobe_width_a: assert property ((m0[1:0] == 2'h2 || m0[2:1] == 2'h2) &&
    $fell(cnt_out[0]) |-> ##[1:30] cnt_out[0])
    else $error("strobe low too long");
  tc_hold_a: assert property (m0 == 3'h0 && cnt_out[0] && !wrote && !wr0 |=> cnt_out[0])
    else $error("mode 0 output fell without a write");
endmodule // tcc_monitor

bind tcc_top tcc_monitor mon (.core_clk(core_clk), .rst(rst), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .cnt_clk_pin(cnt_clk_pin), .cnt_gate_pin(cnt_gate_pin), .cnt_out(cnt_out));

// >>> test/tcc_pin_src.sv
// Channel clock source standing in for the external pins
`timescale 1ns/1ps
module tcc_pin_src (
  input  wire logic       core_clk,
  input  wire logic       run,
  output logic      [2:0] cnt_clk_pin
);
  logic [2:0] ph;
  // Stands high while stopped, so no stray falling edge counts
  always @(posedge core_clk) begin
    ph <= (run && ph != 3'h5) ? ph + 3'h1 : 3'h0;
    if (!run)
      cnt_clk_pin <= 3'h7;
    else if (ph == 3'h5)
      cnt_clk_pin <= ~cnt_clk_pin;
  end
endmodule // tcc_pin_src

// >>> test/tb.sv
// Self-checking bench of the interval counter
`timescale 1ns/1ps
module tb
  import tcc_pkg::*;
;
  logic         core_clk, rst, run;
  tcc_bus_req_s req;
  logic [7:0]   rdata, b;
  logic [2:0]   gate, out, clkp;
  logic [15:0]  lfsr, v1, v2;
  int           bad_count, n_tests, t, ch, n, m, lows, hr, lr;
  tcc_top dut (.core_clk(core_clk), .rst(rst), .bus_req(req), .bus_rdata(rdata),
    .cnt_clk_pin(clkp), .cnt_gate_pin(gate), .cnt_out(out));
  tcc_pin_src src (.core_clk(core_clk), .run(run), .cnt_clk_pin(clkp));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk);
    req.wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge core_clk);
    req.rd <= 1'b0;
    @(posedge core_clk);
    d = rdata;
  endtask
  task automatic latch(input int c, output logic [15:0] v);
    logic [7:0] lo, hi;
    wr(4'hc, 8'(c << 6));
    rd(4'(c * 4), lo);
    rd(4'(c * 4), hi);
    v = {hi, lo};
  endtask
  // Waits for channel clock rises; a stuck clock ends the run
  task automatic ticks(input int k);
    int w;
    logic p;
    repeat (k) begin
      w = 0;
      do begin
        p = clkp[0];
        @(posedge core_clk);
        w++;
      end while (!(clkp[0] === 1'b1 && p === 1'b0) && w < 40);
      if (w >= 40) begin
        bad_count++;
        $display("ERROR %0t channel clock stuck", $time);
        conclude();
      end
    end
  endtask
  // Counts lows, then skips a partial run and measures the next two
  task automatic samp(input int c, input int k, output int lo_n, output int h, output int l);
    logic s[$];
    int i, a;
    lo_n = 0;
    h = 0;
    l = 0;
    repeat (k) begin
      ticks(1);
      s.push_back(out[c]);
      lo_n += int'(out[c] === 1'b0);
    end
    i = 1;
    while (i < k && s[i] === s[0]) i++;
    repeat (2) begin
      a = i;
      while (a < k && s[a] === s[i]) a++;
      if (s[i] === 1'b1) h = a - i;
      else l = a - i;
      i = a;
    end
  endtask
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int m_hi(int md, int k);
    return md == 2 ? k - 1 : (k + 1) / 2;
  endfunction
  function automatic int m_lo(int md, int k);
    return md == 2 ? 1 : k / 2;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    req = '0;
    gate = 3'h0;
    run = 1'b0;
    lfsr = 16'h8c84;
    bad_count = 0;
    n_tests = 0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(4'h2, b);
    check({8'h00, b}, 16'h0000);
    run <= 1'b1;
    gate <= 3'h7;
    for (t = 0; t < 6; t++) begin
      ch = t % 3;
      lfsr = lfsr_next(lfsr);
      n = 3 + int'(lfsr[2:0]);
      m = t[0] ? 3 : 2;
      wr(4'hc, {ch[1:0], 2'h1, (t == 4) ? 3'h6 : {2'h1, t[0]}, t == 5});
      wr(4'(ch * 4), (t == 5) ? 8'h12 : 8'(n));
      if (t == 5) n = 12;
      samp(ch, 40, lows, hr, lr);
      check(16'(hr), 16'(m_hi(m, n)));
      check(16'(lr), 16'(m_lo(m, n)));
      $display("rate test ch %0d mode %0d count %0d done", ch, m, n);
    end
    wr(4'hc, 8'h14);
    wr(4'h0, 8'h04);
    wr(4'hc, 8'hf0);
    samp(0, 20, lows, hr, lr);
    check(16'(hr), 16'h0003);
    gate <= 3'h6;
    samp(0, 10, lows, hr, lr);
    check(16'(lows), 16'h0000);
    wr(4'h0, 8'h06);
    gate <= 3'h7;
    samp(0, 20, lows, hr, lr);
    check(16'(hr), 16'h0005);
    $display("gate and reload test done");
    wr(4'hc, 8'h30);
    check({15'h0000, out[0]}, 16'h0000);
    wr(4'h0, 8'h20);
    wr(4'h0, 8'h00);
    ticks(4);
    latch(0, v1);
    ticks(2);
    latch(0, v2);
    check(16'(v1 > v2), 16'h0001);
    wr(4'h0, 8'h50);
    ticks(3);
    latch(0, v1);
    ticks(3);
    latch(0, v2);
    check(v2, v1);
    wr(4'h0, 8'h00);
    ticks(3);
    latch(0, v1);
    check(16'(v1 < 16'h0050 && v1 > 16'h0048), 16'h0001);
    wr(4'hc, 8'h10);
    wr(4'h0, 8'h03);
    ticks(8);
    samp(0, 6, lows, hr, lr);
    check(16'(lows), 16'h0000);
    $display("mode 0 test done");
    gate <= 3'h5;
    wr(4'hc, 8'h58);
    wr(4'h4, 8'h03);
    samp(1, 8, lows, hr, lr);
    check(16'(lows), 16'h0000);
    gate <= 3'h7;
    samp(1, 10, lows, hr, lr);
    check(16'(lows), 16'h0001);
    $display("strobe test done");
    gate <= 3'h3;
    wr(4'hc, 8'hb2);
    wr(4'h8, 8'h04);
    wr(4'h8, 8'h00);
    ticks(2);
    gate <= 3'h7;
    fork
      samp(2, 14, lows, hr, lr);
      begin
        ticks(2);
        wr(4'h8, 8'h06);
        wr(4'h8, 8'h00);
        latch(2, v1);
      end
    join
    check(16'(lows), 16'h0004);
    check(16'(v1 <= 16'h0004), 16'h0001);
    gate <= 3'h3;
    ticks(2);
    gate <= 3'h7;
    samp(2, 14, lows, hr, lr);
    check(16'(lows), 16'h0006);
    gate <= 3'h3;
    wr(4'hc, 8'hba);
    wr(4'h8, 8'h03);
    wr(4'h8, 8'h00);
    samp(2, 8, lows, hr, lr);
    check(16'(lows), 16'h0000);
    gate <= 3'h7;
    samp(2, 10, lows, hr, lr);
    check(16'(lows), 16'h0001);
    $display("trigger test done");
    run <= 1'b0;
    repeat (20) @(posedge core_clk);
    conclude();
  end
endmodule // tb
